/* File: hw/sea_front_end.v */
// Two-wire client front end: reset hold-off, address decode, data line drive, write gating
`timescale 1ns/100ps
`include "sea_map.vh"

module sea_front_end (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_b,
	// Supply monitor
	input  wire       power_good,
	// Bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	// Strap and protect pins
	input  wire       hw_addr_bit0_pin,
	input  wire       hw_addr_bit1_pin,
	input  wire       hw_addr_bit2_pin,
	input  wire       wp_pin,
	// Configuration state
	input  wire       sw_protect_mode,
	input  wire       sw_protect_block,
	input  wire       config_locked,
	input  wire       config_write_req,
	// Decode results
	output reg        ready,
	output reg        sel_array,
	output reg        sel_regs,
	output reg        sel_mfg_id,
	output reg        sel_hs_mode,
	output reg        rd_not_wr,
	output reg        addr_valid,
	output reg        start_seen,
	output reg        stop_seen,
	output reg        write_allow,
	output reg        config_write_allow
);

	localparam ST_RESET = 3'h0;
	localparam ST_IDLE  = 3'h1;
	localparam ST_SHIFT = 3'h2;
	localparam ST_ACK   = 3'h3;
	localparam ST_BUSY  = 3'h4;
	localparam ST_SKIP  = 3'h5;

	// Sizes of the storage that sits behind this front end
	localparam ARRAY_BYTES = `SEA_PAGE_COUNT * `SEA_PAGE_BYTES;
	localparam SERIAL_BITS = `SEA_SERIAL_BITS;

	reg  [2:0] state_r;
	reg  [2:0] state_nxt;
	reg  [7:0] shift_r;
	reg  [3:0] bitcnt_r;
	reg        scl_d_r;
	reg        sda_d_r;
	reg        match_r;
	reg  [2:0] hwa_r;
	wire       scl_s;
	wire       sda_s;
	wire       a0_s;
	wire       a1_s;
	wire       a2_s;
	wire       wp_s;
	wire       pg_s;
	wire       pg_fail_s;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	sea_pin_sync u_scl (.clk(clk), .rst_b(rst_b), .pin_in(scl_in),           .level_out(scl_s));
	sea_pin_sync u_sda (.clk(clk), .rst_b(rst_b), .pin_in(sda_in),           .level_out(sda_s));
	sea_pin_sync u_a0  (.clk(clk), .rst_b(rst_b), .pin_in(hw_addr_bit0_pin), .level_out(a0_s));
	sea_pin_sync u_a1  (.clk(clk), .rst_b(rst_b), .pin_in(hw_addr_bit1_pin), .level_out(a1_s));
	sea_pin_sync u_a2  (.clk(clk), .rst_b(rst_b), .pin_in(hw_addr_bit2_pin), .level_out(a2_s));
	sea_pin_sync u_wp  (.clk(clk), .rst_b(rst_b), .pin_in(wp_pin),           .level_out(wp_s));
	// Power-good runs inverted: a filter preset high then reads as supply absent
	sea_pin_sync u_pg  (.clk(clk), .rst_b(rst_b), .pin_in(~power_good),      .level_out(pg_fail_s));
	assign pg_s = ~pg_fail_s;

	// ----------------------------------------
	// Bus conditions
	// ----------------------------------------
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// Decode of the completed address byte
	wire [7:0] ab      = shift_r;
	wire [3:0] ab_type = ab[`SEA_TYPE_MSB:`SEA_TYPE_LSB];
	wire       hwa_ok  = (ab[`SEA_HWA_MSB:`SEA_HWA_LSB] == hwa_r);
	wire       is_arr  = (ab_type == `SEA_TYPE_ARRAY) & hwa_ok;
	wire       is_reg  = (ab_type == `SEA_TYPE_REGS) & hwa_ok;
	wire       is_mfg  = (ab[7:1] == `SEA_HOST_MFG);
	wire       is_hs   = (ab[7:3] == `SEA_HOST_HS_TOP);
	// The HS host code is left out on purpose: it is never answered
	wire       hit     = is_arr | is_reg | is_mfg;

	// ----------------------------------------
	// Control state machine
	// ----------------------------------------
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: begin
				if (pg_s) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (start_c) begin
					state_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (scl_fall && bitcnt_r == 4'h8) begin
					state_nxt = hit ? ST_ACK : ST_SKIP;
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					state_nxt = ST_BUSY;
				end
			end
			ST_BUSY: begin
				state_nxt = ST_BUSY;
			end
			ST_SKIP: begin
				state_nxt = ST_SKIP;
			end
			default: begin
				state_nxt = ST_RESET;
			end
		endcase
		if (state_r != ST_RESET) begin
			if (!pg_s) begin
				state_nxt = ST_RESET;
			end else if (stop_c) begin
				state_nxt = ST_IDLE;
			end else if (start_c) begin
				state_nxt = ST_SHIFT;
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r            <= ST_RESET;
			shift_r            <= 8'h00;
			bitcnt_r           <= 4'h0;
			scl_d_r            <= 1'b1;
			sda_d_r            <= 1'b1;
			match_r            <= 1'b0;
			hwa_r              <= 3'h0;
			sda_out            <= 1'b0;
			sda_oe             <= 1'b0;
			ready              <= 1'b0;
			sel_array          <= 1'b0;
			sel_regs           <= 1'b0;
			sel_mfg_id         <= 1'b0;
			sel_hs_mode        <= 1'b0;
			rd_not_wr          <= 1'b0;
			addr_valid         <= 1'b0;
			start_seen         <= 1'b0;
			stop_seen          <= 1'b0;
			write_allow        <= 1'b0;
			config_write_allow <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			scl_d_r    <= scl_s;
			sda_d_r    <= sda_s;
			ready      <= (state_r != ST_RESET);
			start_seen <= start_c & (state_r != ST_RESET);
			stop_seen  <= stop_c & (state_r != ST_RESET);
			addr_valid <= 1'b0;
			// Straps read through the filter; external logic must hold them steady
			hwa_r      <= {a2_s, a1_s, a0_s};
			// Pin level ignored under software protection, configuration decides
			write_allow        <= sw_protect_mode ? ~sw_protect_block : ~wp_s;
			config_write_allow <= config_write_req & ~config_locked;
			if (start_c) begin
				shift_r    <= 8'h00;
				bitcnt_r   <= 4'h0;
				match_r    <= 1'b0;
			end else if (state_r == ST_SHIFT && scl_rise && bitcnt_r != 4'h8) begin
				shift_r  <= {shift_r[6:0], sda_s};
				bitcnt_r <= bitcnt_r + 4'h1;
			end
			if (state_r == ST_SHIFT && scl_fall && bitcnt_r == 4'h8) begin
				match_r     <= hit;
				addr_valid  <= 1'b1;
				sel_array   <= is_arr;
				sel_regs    <= is_reg;
				sel_mfg_id  <= is_mfg;
				sel_hs_mode <= is_hs;
				rd_not_wr   <= ab[`SEA_RW_BIT];
			end
			if (stop_c || state_r == ST_RESET) begin
				sel_array   <= 1'b0;
				sel_regs    <= 1'b0;
				sel_mfg_id  <= 1'b0;
				sel_hs_mode <= 1'b0;
			end
			// Pull low for acknowledge only; high level comes from the pull-up
			sda_out <= 1'b0;
			sda_oe  <= (state_nxt == ST_ACK) & pg_s;
		end
	end

endmodule // sea_front_end

/* File: hw/sea_map.vh */
// Constants for the serial EEPROM client address front end
`ifndef SEA_MAP_VH
`define SEA_MAP_VH

// ----------------------------------------
// Device address byte fields
// ----------------------------------------
`define SEA_TYPE_MSB        7
`define SEA_TYPE_LSB        4
`define SEA_HWA_MSB         3
`define SEA_HWA_LSB         1
`define SEA_RW_BIT          0
`define SEA_TYPE_ARRAY      4'hA
`define SEA_TYPE_REGS       4'hB
`define SEA_HOST_MFG        7'h7C
`define SEA_HOST_HS_TOP     5'h01

// ----------------------------------------
// Array organisation and register sizes
// ----------------------------------------
`define SEA_PAGE_COUNT      512
`define SEA_PAGE_BYTES      64
`define SEA_SERIAL_BITS     128
`define SEA_MFG_ID_BITS     24

// ----------------------------------------
// Timing
// ----------------------------------------
`define SEA_CLK_MHZ         40
`define SEA_PUP_WAIT_US     100
`define SEA_PUP_WAIT_CYC    (`SEA_PUP_WAIT_US * `SEA_CLK_MHZ)

`endif

/* File: hw/sea_pin_sync.v */
// Three-stage synchroniser with agreement filter for slow pins
`timescale 1ns/100ps

module sea_pin_sync (
	// Clock and reset
	input  wire clk,
	input  wire rst_b,
	// Pin and filtered level
	input  wire pin_in,
	output reg  level_out
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// A change counts once stages two and three agree
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r      <= 1'b1;
			s2_r      <= 1'b1;
			s3_r      <= 1'b1;
			level_out <= 1'b1;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_out <= s3_r;
			end
		end
	end

endmodule // sea_pin_sync

/* File: testbench/sea_front_end_assertions.sv */
// Checker for the two-wire client front end
`timescale 1ns/100ps
module sea_front_end_assertions (
	input wire clk, rst_b, power_good, wp_pin, sw_protect_mode, sw_protect_block, config_locked,
	input wire ready, sda_out, sda_oe, addr_valid, sel_array, sel_regs, sel_mfg_id, sel_hs_mode,
	input wire stop_seen, write_allow, config_write_allow
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire any_sel = sel_array | sel_regs | sel_mfg_id;
	sequence s_ack_rise; !sda_oe ##1 sda_oe; endsequence
	sequence s_cleared; ##[0:1] !(any_sel | sel_hs_mode); endsequence
	quiet_reset_a: assert property (sda_oe |-> ready) else $error("ack in reset");
	power_drop_a: assert property (!power_good [*8] |-> !ready) else $error("ready unpowered");
	open_drain_a: assert property (sda_oe |-> !sda_out) else $error("sda driven high");
	ack_cause_a: assert property (s_ack_rise |-> addr_valid) else $error("ack unprompted");
	ack_select_a: assert property (s_ack_rise |-> any_sel) else $error("ack unselected");
	hs_silent_a: assert property (sel_hs_mode |-> !sda_oe) else $error("hs code acked");
	valid_pulse_a: assert property (addr_valid |=> !addr_valid) else $error("long pulse");
	stop_clear_a: assert property (stop_seen |-> s_cleared) else $error("select kept");
	wp_block_a: assert property ((!sw_protect_mode && wp_pin) [*8] |=> !write_allow) else $error("wp open");
	sw_mode_a: assert property ((sw_protect_mode && !sw_protect_block) [*3] |=> write_allow) else $error("sw");
	lock_hold_a: assert property (config_locked |=> !config_write_allow) else $error("lock open");
endmodule // sea_front_end_assertions
bind sea_front_end sea_front_end_assertions CHK (.clk, .rst_b, .power_good, .wp_pin, .sw_protect_mode,
	.sw_protect_block, .config_locked, .ready, .sda_out, .sda_oe, .addr_valid, .sel_array, .sel_regs,
	.sel_mfg_id, .sel_hs_mode, .stop_seen, .write_allow, .config_write_allow);

/* File: testbench/sea_front_end_bench.sv */
// Self-checking bench for the two-wire client front end
`timescale 1ns/100ps
`include "sea_map.vh"
module sea_front_end_bench;
	reg clk = 1'b0, rst_b = 1'b0, power_good = 1'b0, wp_pin = 1'b0, sw_protect_mode = 1'b0;
	reg sw_protect_block = 1'b0, config_locked = 1'b0, config_write_req = 1'b0;
	reg [2:0] hw = 3'h0;
	wire sda_out, sda_oe, ready, sel_array, sel_regs, sel_mfg_id, sel_hs_mode, rd_not_wr, addr_valid;
	wire start_seen, stop_seen, write_allow, config_write_allow, scl, sda_low, ack_pulse, ack_bit;
	wire sda = !(sda_low | (sda_oe & !sda_out));
	reg [7:0] exq[$];
	reg [7:0] got;
	integer fail_count = 0, comparisons = 0, i;
	integer starts = 0, stops = 0;
	always #12.5 clk = !clk;
	sea_front_end DUT (.clk, .rst_b, .power_good, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
		.hw_addr_bit0_pin(hw[0]), .hw_addr_bit1_pin(hw[1]), .hw_addr_bit2_pin(hw[2]), .wp_pin,
		.sw_protect_mode, .sw_protect_block, .config_locked, .config_write_req, .ready, .sel_array,
		.sel_regs, .sel_mfg_id, .sel_hs_mode, .rd_not_wr, .addr_valid, .start_seen, .stop_seen,
		.write_allow, .config_write_allow);
	sea_host_model HOST (.clk, .sda, .scl, .sda_low, .ack_pulse, .ack_bit);
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Extra bytes follow a failed compare in the same frame and must stay unanswered
	task xfer(input [7:0] b, input integer extra);
		reg [7:0] e;
		integer s0, p0;
		{wp_pin, sw_protect_mode, sw_protect_block, config_locked, config_write_req} <= 5'($urandom);
		HOST.tick(8);
		e[6] = b[7:4] == `SEA_TYPE_ARRAY && b[3:1] == hw && power_good;
		e[5] = b[7:4] == `SEA_TYPE_REGS && b[3:1] == hw && power_good;
		e[4] = b[7:1] == `SEA_HOST_MFG && power_good;
		e[3] = b[7:3] == `SEA_HOST_HS_TOP && power_good;
		e[7] = |e[6:4];
		e[2] = b[0] & e[7];
		e[1] = sw_protect_mode ? !sw_protect_block : !wp_pin;
		e[0] = config_write_req & !config_locked;
		exq.push_back(e);
		s0 = starts;
		p0 = stops;
		HOST.start_c;
		HOST.send(b);
		repeat (extra) begin
			exq.push_back(e & 8'h03);
			HOST.send({`SEA_TYPE_ARRAY, hw, 1'b0});
		end
		HOST.stop_c;
		comparisons = comparisons + 1;
		if (starts - s0 !== power_good || stops - p0 !== power_good) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %0t start or stop count", $time);
		end
		$display("Test with byte %h done", b);
	endtask
	always @(posedge clk) begin
		if (start_seen === 1'b1) starts = starts + 1;
		if (stop_seen === 1'b1) stops = stops + 1;
		if (ack_pulse === 1'b1) begin
			got = {!ack_bit, sel_array, sel_regs, sel_mfg_id, sel_hs_mode,
				rd_not_wr & (sel_array | sel_regs | sel_mfg_id), write_allow, config_write_allow};
			comparisons = comparisons + 1;
			if (got !== exq.pop_front()) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED %0t ack or decode %h", $time, got);
			end
		end
	end
	initial begin
		repeat (30000) @(posedge clk);
		fail_count = fail_count + 1;
		give_verdict;
	end
	initial begin
		i = $urandom(38406);
		HOST.tick(8);
		rst_b <= 1'b1;
		xfer({`SEA_TYPE_ARRAY, 3'h0, 1'b0}, 0);
		power_good <= 1'b1;
		HOST.tick(`SEA_PUP_WAIT_CYC);
		for (i = 0; i < 8; i++) begin
			hw <= i[2:0];
			HOST.tick(8);
			xfer({`SEA_TYPE_ARRAY, hw, i[0]}, 0);
			xfer({`SEA_TYPE_REGS, hw, !i[0]}, 0);
			xfer({`SEA_HOST_MFG, i[1]}, 0);
			xfer({`SEA_HOST_HS_TOP, i[2:0]}, 0);
			xfer({`SEA_TYPE_ARRAY, hw ^ (3'h1 << (i % 3)), 1'b0}, 1);
			xfer(8'($urandom), 0);
		end
		power_good <= 1'b0;
		xfer({`SEA_TYPE_ARRAY, hw, 1'b1}, 0);
		give_verdict;
	end
endmodule // sea_front_end_bench

/* File: testbench/sea_host_model.sv */
// Two-wire bus host model: drives the clock, frames bytes, samples the ack
`timescale 1ns/100ps
module sea_host_model (
	input  wire clk,
	input  wire sda,
	output reg  scl = 1'b1,
	output reg  sda_low = 1'b0,
	output reg  ack_pulse = 1'b0,
	output reg  ack_bit = 1'b1
);
	task tick(input integer n); repeat (n) @(posedge clk); endtask
	// Clock stands high between frames; 8 cycles give the 200 ns bit period
	task start_c; sda_low <= 1'b1; tick(4); scl <= 1'b0; tick(2); endtask
	task stop_c; sda_low <= 1'b1; tick(2); scl <= 1'b1; tick(4); sda_low <= 1'b0; tick(8); endtask
	task send(input [7:0] b);
		integer i;
		for (i = 7; i >= 0; i--) begin
			sda_low <= !b[i]; tick(2); scl <= 1'b1; tick(4); scl <= 1'b0; tick(2);
		end
		// Long low phases: the device sees the pins through a filter and lets go of its ack late
		sda_low <= 1'b0; tick(4); scl <= 1'b1; tick(3);
		ack_bit <= sda; ack_pulse <= 1'b1; tick(1); ack_pulse <= 1'b0; scl <= 1'b0; tick(4);
	endtask
endmodule // sea_host_model
